// [verilog/swp_pkg.sv]
// Constants, types and timing for the two-wire serial EEPROM block.
// Assumes a 25 MHz reference clock; the serial clock arrives on a pin.
//
// Operation
// - Serial data is sampled on the rising serial clock edge and the data line is changed only after the falling edge.
// - The data line is open-drain, so the device only ever pulls it low or lets it go.
// - Three strapped chip-select inputs give each device its own identity, allowing eight on one bus.
// - The device answers only when the received select bits equal its three chip-select inputs.
// - A chip-select or write-protect input left open reads as low through a pad pull-down.
// - A high write-protect input blocks every write to the whole array regardless of the software flags.
// - With write-protect low, either software flag blocks writes to bytes 00h to 7Fh, and with neither set all is writable.
// - Once the permanent protection flag is set it is never cleared again.
// - The reversible protection flag is set by one special command and cleared by another.
// - The array holds 256 bytes as 16 pages of 16 bytes, reached by an 8-bit word address.
// - Page writes of up to 16 bytes are accepted, and shorter partial-page writes too.
// - After a write transfer the device finishes its self-timed programming cycle within 5 ms.
// - The address byte carries 1010 for memory or 0110 for protection, then the select bits, then read high or write low.
// - Bytes move eight bits at a time and each received byte is acknowledged by pulling data low in the ninth clock.
// - A write to a protected location is acknowledged but not stored, and the full write cycle still runs.
// - During a page write only the low four address bits advance, wrapping within the same page.

package swp_pkg;

  // ****************************************
  // Clock and programming time
  // ****************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int PROG_TIME_US   = 5000;   // internal_program_duration
  localparam int PROG_CYCLES    = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W          = 17;

  // ****************************************
  // Array geometry and protection boundary
  // ****************************************
  localparam int PAGE_BYTES     = 16;
  localparam int MEM_BYTES      = 256;
  localparam logic [7:0] LOW_HALF_TOP = 8'h7f;

  // ****************************************
  // Address byte codes and bit counts
  // ****************************************
  localparam logic [3:0] CTL_MEM   = 4'ha;
  localparam logic [3:0] CTL_FLAG  = 4'h6;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // Protection command selected by the low word-address bits
  localparam logic [1:0] FOP_SET_PERM = 2'h0;
  localparam logic [1:0] FOP_SET_REV  = 2'h1;
  localparam logic [1:0] FOP_CLR_REV  = 2'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] PTR_RST  = 8'h00;
  localparam logic [3:0] CNT_RST  = 4'h0;

  typedef enum
  {
    SWP_IDLE,
    SWP_DEV,
    SWP_WORD,
    SWP_WDATA,
    SWP_RDATA
  } swp_link_e;

  // Pending program request, handed from link side to core side
  typedef struct packed
  {
    logic        is_flag;
    logic [1:0]  flag_op;
    logic [3:0]  page;
    logic [15:0] mask;
  } swp_commit_s;

endpackage

// [verilog/swp_sync.sv]
// Two-flop level synchroniser of configurable width.
// Assumes the inputs change slowly compared with the sampling clock.
`timescale 1ns/1ns

module swp_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    meta  <= d_in;
    q_out <= meta;
  end

endmodule

// [verilog/swp_eeprom_top.sv]
// Two-wire serial EEPROM slave with page write and write protection.
// Assumes the serial clock runs only during frames and that the pad
// provides pull-downs on the strap and write-protect inputs.
`timescale 1ns/1ns

module swp_eeprom_top
  import swp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)
(
  input  wire logic ref_clk_in,
  input  wire logic nrst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic chip_select_bit_0_in,
  input  wire logic chip_select_bit_1_in,
  input  wire logic chip_select_bit_2_in,
  input  wire logic wp_in,
  output logic      busy_out,
  output logic      permanent_protect_flag_out,
  output logic      reversible_protect_flag_out
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Write block test for one byte address
  function automatic logic wr_blocked(input logic [7:0] a,
                                      input logic       wp,
                                      input logic       perm,
                                      input logic       rev);
    logic low_half;
    low_half = (a <= LOW_HALF_TOP);
    return wp | ((perm | rev) & low_half);
  endfunction

  // Protection command from the word-address byte
  function automatic logic [1:0] fop_decode(input logic [7:0] b);
    logic [1:0] op;
    op = FOP_SET_PERM;
    if (b[1:0] == 2'b01)
      op = FOP_SET_REV;
    else if (b[1:0] == 2'b10)
      op = FOP_CLR_REV;
    return op;
  endfunction

  // ****************************************
  // Shared storage and flags
  // ****************************************
  logic [7:0]  mem [MEM_BYTES];
  logic [7:0]  pbuf [PAGE_BYTES];
  logic        perm_flag = 1'b0;          // Nonvolatile, reset ignores
  logic        rev_flag  = 1'b0;          // Nonvolatile, reset ignores
  logic        busy;
  logic [TMR_W-1:0] tmr;

  // ****************************************
  // Start and stop detectors
  // ****************************************
  logic start_tog = 1'b0;
  logic stop_tog  = 1'b0;

  // Falling data with clock high marks a start
  always_ff @(negedge sda_in)
  begin
    if (scl_in)
      start_tog <= ~start_tog;
  end

  // Rising data with clock high marks a stop
  always_ff @(posedge sda_in)
  begin
    if (scl_in)
      stop_tog <= ~stop_tog;
  end

  // ****************************************
  // Link side: serial clock domain
  // ****************************************
  logic [5:0]  scl_s;
  logic        scl_rst_n;
  logic        busy_l;
  logic        perm_l;
  logic [2:0]  cs_l;

  // Reset, core state and straps into the serial clock domain
  swp_sync #(.W(6)) u_scl_sync
  (
    .clk_in (scl_in),
    .d_in   ({nrst_in, busy, perm_flag, chip_select_bit_2_in,
              chip_select_bit_1_in, chip_select_bit_0_in}),
    .q_out  (scl_s)
  );

  assign scl_rst_n = scl_s[5];
  assign busy_l    = scl_s[4];
  assign perm_l    = scl_s[3];
  assign cs_l      = scl_s[2:0];

  swp_link_e   state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  rd_sh;
  logic [7:0]  ptr;
  logic        is_flag;
  logic        drv_low;
  logic        armed;
  logic        start_seen;
  swp_commit_s cmd;
  logic        start_pend;
  logic [7:0]  rx_byte;
  logic [7:0]  rd_byte;
  logic        dev_ok;
  logic        wr_byte;

  // Byte assembly and address byte check
  always_comb
  begin
    start_pend = start_tog ^ start_seen;
    rx_byte    = {shreg[6:0], sda_in};
    rd_byte    = mem[ptr];
    dev_ok     = (rx_byte[3:1] == cs_l)
                 && !busy_l
                 && ((rx_byte[7:4] == CTL_MEM)
                     || ((rx_byte[7:4] == CTL_FLAG) && !perm_l
                         && !rx_byte[0]));
    wr_byte    = scl_rst_n && !start_pend && (state == SWP_WDATA)
                 && (bit_cnt == BIT_LAST) && !is_flag;
  end

  // Protocol engine on the rising serial clock
  always_ff @(posedge scl_in)
  begin
    if (!scl_rst_n)
    begin
      state      <= SWP_IDLE;
      bit_cnt    <= CNT_RST;
      shreg      <= 8'h00;
      rd_sh      <= 8'h00;
      ptr        <= PTR_RST;
      is_flag    <= 1'b0;
      drv_low    <= 1'b0;
      armed      <= 1'b0;
      start_seen <= start_tog;
      cmd        <= '0;
    end
    else if (start_pend)
    begin
      // First address bit rides on this edge
      start_seen <= start_tog;
      state      <= SWP_DEV;
      bit_cnt    <= 4'h1;
      shreg      <= {7'h00, sda_in};
      drv_low    <= 1'b0;
      armed      <= 1'b0;
      cmd        <= '0;
    end
    else if (state == SWP_IDLE)
    begin
      drv_low <= 1'b0;
    end
    else if (bit_cnt == BIT_ACK)
    begin
      // Ninth clock: read path loads the next byte on a low level
      bit_cnt <= CNT_RST;
      if ((state == SWP_RDATA) && !sda_in)
      begin
        rd_sh   <= {rd_byte[6:0], 1'b0};
        drv_low <= ~rd_byte[7];
        ptr     <= ptr + 8'h01;
      end
      else
      begin
        drv_low <= 1'b0;
        if (state == SWP_RDATA)
          state <= SWP_IDLE;               // Master ended the read
      end
    end
    else if (bit_cnt == BIT_LAST)
    begin
      bit_cnt <= BIT_ACK;
      case (state)
        SWP_DEV:
        begin
          drv_low <= dev_ok;
          is_flag <= (rx_byte[7:4] == CTL_FLAG);
          if (!dev_ok)
            state <= SWP_IDLE;
          else if (rx_byte[0])
            state <= SWP_RDATA;
          else
            state <= SWP_WORD;
        end
        SWP_WORD:
        begin
          drv_low <= 1'b1;
          ptr     <= rx_byte;
          state   <= SWP_WDATA;
          if (is_flag)
          begin
            armed       <= 1'b1;
            cmd.is_flag <= 1'b1;
            cmd.flag_op <= fop_decode(rx_byte);
          end
          else
            cmd.page <= rx_byte[7:4];
        end
        SWP_WDATA:
        begin
          drv_low <= 1'b1;
          if (!is_flag)
          begin
            armed             <= 1'b1;
            cmd.mask[ptr[3:0]] <= 1'b1;
            ptr[3:0]          <= ptr[3:0] + 4'h1;
          end
        end
        SWP_RDATA:
        begin
          drv_low <= 1'b0;                 // Free line for master ack
        end
        default:
        begin
          drv_low <= 1'b0;
          state   <= SWP_IDLE;
        end
      endcase
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg   <= rx_byte;
      if (state == SWP_RDATA)
      begin
        drv_low <= ~rd_sh[7];
        rd_sh   <= {rd_sh[6:0], 1'b0};
      end
    end
  end

  // Page buffer capture, one slot per low address value
  always_ff @(posedge scl_in)
  begin
    if (wr_byte)
      pbuf[ptr[3:0]] <= rx_byte;
  end

  // Data line drive changes only after the falling edge
  always_ff @(negedge scl_in)
  begin
    if (!scl_rst_n)
      sda_oe_out <= 1'b0;
    else
      sda_oe_out <= drv_low;
  end

  // ****************************************
  // Core side: reference clock domain
  // ****************************************
  logic [2:0] ref_s;
  logic       wp_s;
  logic       stop_s;
  logic       armed_s;
  logic       stop_d;
  logic       go;
  logic       mem_go;
  logic       flag_go;

  swp_sync #(.W(3)) u_ref_sync
  (
    .clk_in (ref_clk_in),
    .d_in   ({wp_in, stop_tog, armed}),
    .q_out  (ref_s)
  );

  assign wp_s    = ref_s[2];
  assign stop_s  = ref_s[1];
  assign armed_s = ref_s[0];

  // Stop event starts a program cycle when a write is armed
  always_comb
  begin
    go      = nrst_in && (stop_s ^ stop_d) && armed_s && !busy;
    mem_go  = go && !cmd.is_flag;
    flag_go = go && cmd.is_flag && !wp_s;
  end

  // Stop edge history
  always_ff @(posedge ref_clk_in)
  begin
    stop_d <= stop_s;                      // No false stop edge after reset
  end

  // Self-timed program cycle, runs even when writes are blocked
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      busy <= 1'b0;
      tmr  <= '0;
    end
    else if (go)
    begin
      busy <= 1'b1;
      tmr  <= TMR_W'(PROG_CYC - 1);
    end
    else if (busy)
    begin
      if (tmr == '0)
        busy <= 1'b0;
      else
        tmr <= tmr - 1'b1;
    end
  end

  // Array update from the page buffer, protected bytes skipped
  always_ff @(posedge ref_clk_in)
  begin
    if (mem_go)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (cmd.mask[i] && !wr_blocked({cmd.page, 4'(i)}, wp_s,
                                       perm_flag, rev_flag))
          mem[{cmd.page, 4'(i)}] <= pbuf[i];
      end
    end
  end

  // Permanent flag only ever sets
  always_ff @(posedge ref_clk_in)
  begin
    if (flag_go && (cmd.flag_op == FOP_SET_PERM))
      perm_flag <= 1'b1;
  end

  // Reversible flag set and clear commands
  always_ff @(posedge ref_clk_in)
  begin
    if (flag_go && (cmd.flag_op == FOP_SET_REV))
      rev_flag <= 1'b1;
    else if (flag_go && (cmd.flag_op == FOP_CLR_REV))
      rev_flag <= 1'b0;
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      sda_out                     <= 1'b0;
      busy_out                    <= 1'b0;
      permanent_protect_flag_out  <= 1'b0;
      reversible_protect_flag_out <= 1'b0;
    end
    else
    begin
      sda_out                     <= 1'b0;
      busy_out                    <= busy;
      permanent_protect_flag_out  <= perm_flag;
      reversible_protect_flag_out <= rev_flag;
    end
  end

endmodule

// [testbench/swp_eeprom_monitor.sv]
// Concurrent checks on the EEPROM block pins.
// Assumes binding into the top module, reference clock domain.
`timescale 1ns/1ns

module swp_eeprom_monitor
  import swp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic wp_in,
  input wire logic busy_out,
  input wire logic permanent_protect_flag_out,
  input wire logic reversible_protect_flag_out
);
  int   busy_cnt;
  logic oe_at_rise;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // Cycles of the current busy period
  always_ff @(posedge ref_clk_in)
    busy_cnt <= busy_out ? busy_cnt + 1 : 0;

  // Pin drive seen at each serial rising edge
  always_ff @(posedge scl_in)
    oe_at_rise <= sda_oe_out;

  sequence wp_steady;
    wp_in [*6];
  endsequence

  a_sda_drive_zero:
    assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_high:
    assert property (scl_in |-> sda_oe_out == oe_at_rise)
    else $error("data drive moved while clock high");
  a_perm_sticky:
    assert property (permanent_protect_flag_out |=> permanent_protect_flag_out)
    else $error("permanent flag cleared");
  a_rev_needs_busy:
    assert property ($changed(reversible_protect_flag_out)
                     && $past(nrst_in, 2) |-> ##[0:3] busy_out)
    else $error("reversible flag moved without cycle");
  a_wp_flag_hold:
    assert property (wp_steady |-> $stable(reversible_protect_flag_out)
                     && $stable(permanent_protect_flag_out))
    else $error("flag changed under write protect");
  a_busy_length:
    assert property ($fell(busy_out) |-> busy_cnt == PROG_CYC)
    else $error("program cycle length wrong");
  a_busy_bound:
    assert property (busy_cnt <= PROG_CYC)
    else $error("program cycle overran");
  a_busy_no_ack:
    assert property (busy_out |-> !sda_oe_out)
    else $error("data driven during program cycle");
endmodule

// [testbench/swp_master_model.sv]
// Behavioural two-wire bus master, clock period 15 ns within frames.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/1ns

module swp_master_model
(
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // Idle: clock stands high, data released
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Data set while clock low, only pulled low or released
  task automatic bit_out(input logic b);
    scl_out = 1'b0;
    #4 sda_low_out = !b;
    #3 scl_out = 1'b1;
    #8;
  endtask

  // Release while clock low, sample in the clock high phase
  task automatic bit_in(output logic b);
    scl_out = 1'b0;
    #4 sda_low_out = 1'b0;
    #3 scl_out = 1'b1;
    #4 b = sda_in;
    #4;
  endtask

  task automatic start_cond;
    bit_out(1'b1);
    sda_low_out = 1'b1;
    #4;
  endtask

  task automatic stop_cond;
    bit_out(1'b0);
    sda_low_out = 1'b0;
    #8;
  endtask

  // Byte MSB first, ack returned high when pulled low
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(a);
    ack = !a;
  endtask

  task automatic byte_in(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(last);
  endtask

  // Free clock pulses with data released, used around reset
  task automatic pulses(input int n);
    repeat (n)
    begin
      scl_out = 1'b0;
      #7 scl_out = 1'b1;
      #8;
    end
  endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench: page writes, select, busy, protection.
// Assumes the master model and the monitor file are compiled first.
`timescale 1ns/1ns

module testbench;
  localparam int PC = 20;
  logic       ref_clk, nrst, wp, sda_oe, busy, perm, rev;
  logic       scl, sda_low, ack, ok, hold;
  logic [2:0] strap, sel;
  logic [7:0] got [4];
  logic [7:0] z   [4] = '{default: 8'h00};
  wire        sda = !(sda_oe || sda_low);
  int         errors, checked;

  swp_eeprom_top #(.PROG_CYC(PC)) dut_u
  (
    .ref_clk_in                  (ref_clk),
    .nrst_in                     (nrst),
    .scl_in                      (scl),
    .sda_in                      (sda),
    .sda_out                     (),
    .sda_oe_out                  (sda_oe),
    .chip_select_bit_0_in        (strap[0]),
    .chip_select_bit_1_in        (strap[1]),
    .chip_select_bit_2_in        (strap[2]),
    .wp_in                       (wp),
    .busy_out                    (busy),
    .permanent_protect_flag_out  (perm),
    .reversible_protect_flag_out (rev)
  );

  swp_master_model m_u (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset;
    #1 nrst = 1'b0;
    fork
      repeat (12) @(posedge ref_clk);
      m_u.pulses(6);
    join
    @(posedge ref_clk);
    #1 nrst = 1'b1;
    m_u.pulses(4);
  endtask

  task automatic wait_idle;
    int k;
    repeat (8) @(posedge ref_clk);
    for (k = 0; k < 4 * PC && busy !== 1'b0; k++)
      @(posedge ref_clk);
    chk("busy end", 8'(busy), 8'h00);
  endtask

  // Write frame: address, word address, n data bytes
  task automatic wr(input logic [3:0] ctl, input logic [7:0] adr,
                    input logic [7:0] d [4], input int n, input logic exp);
    m_u.start_cond();
    m_u.byte_out({ctl, sel, 1'b0}, ack);
    chk("addr ack", 8'(ack), 8'(exp));
    ok = 1'b1;
    if (exp)
    begin
      m_u.byte_out(adr, ack);
      ok &= ack;
      for (int i = 0; i < n; i++)
      begin
        m_u.byte_out(d[i], ack);
        ok &= ack;
      end
      chk("data ack", 8'(ok), 8'h01);
    end
    m_u.stop_cond();
    if (!hold)
      wait_idle();
  endtask

  // Random read of n bytes with repeated start
  task automatic rd(input logic [7:0] adr, input int n);
    m_u.start_cond();
    m_u.byte_out({4'ha, strap, 1'b0}, ack);
    m_u.byte_out(adr, ack);
    m_u.start_cond();
    m_u.byte_out({4'ha, strap, 1'b1}, ack);
    for (int i = 0; i < n; i++)
      m_u.byte_in(got[i], i == n - 1);
    m_u.stop_cond();
    repeat (4) @(posedge ref_clk);
  endtask

  initial
  begin
    #(20000 * 40);
    errors++;
    final_report();
  end

  initial
  begin
    errors = 0;
    checked = 0;
    hold = 1'b0;
    wp = 1'b0;
    strap = 3'b101;
    sel = strap;
    nrst = 1'b0;
    do_reset();
    // Page write wrapping inside its page
    wr(4'ha, 8'h8f, '{8'ha0, 8'ha1, 8'ha2, 8'h00}, 3, 1'b1);
    wr(4'ha, 8'h7f, '{8'h11, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    rd(8'h80, 2);
    chk("wrap 80", got[0], 8'ha1);
    chk("wrap 81", got[1], 8'ha2);
    rd(8'h8f, 1);
    chk("byte 8f", got[0], 8'ha0);
    $display("test page_write done");
    // Every select value, a wrong control code and a protection read
    for (int s = 0; s < 8; s++)
    begin
      sel = s[2:0];
      wr(4'ha, 8'h00, z, 0, s == 5);
    end
    sel = strap;
    wr(4'hb, 8'h00, z, 0, 1'b0);
    m_u.start_cond();
    m_u.byte_out({4'h6, strap, 1'b1}, ack);
    chk("flag read ack", 8'(ack), 8'h00);
    m_u.stop_cond();
    $display("test select done");
    // Polling during program cycle
    hold = 1'b1;
    wr(4'ha, 8'h90, '{8'h5a, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    repeat (6) @(posedge ref_clk);
    #1 chk("busy", 8'(busy), 8'h01);
    wr(4'ha, 8'h90, z, 0, 1'b0);
    hold = 1'b0;
    wait_idle();
    rd(8'h90, 1);
    chk("byte 90", got[0], 8'h5a);
    $display("test polling done");
    // Hardware protection over the whole array
    @(posedge ref_clk);
    #1 wp = 1'b1;
    wr(4'ha, 8'h8f, '{8'hee, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    wr(4'h6, 8'h01, z, 0, 1'b1);
    chk("rev under wp", 8'(rev), 8'h00);
    @(posedge ref_clk);
    #1 wp = 1'b0;
    rd(8'h8f, 1);
    chk("wp blocked", got[0], 8'ha0);
    $display("test hw_protect done");
    // Reversible flag on the half boundary
    wr(4'h6, 8'h01, z, 0, 1'b1);
    chk("rev set", 8'(rev), 8'h01);
    wr(4'ha, 8'h7f, '{8'h22, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    wr(4'ha, 8'h80, '{8'h33, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    rd(8'h7f, 2);
    chk("low half", got[0], 8'h11);
    chk("high half", got[1], 8'h33);
    wr(4'h6, 8'h02, z, 0, 1'b1);
    chk("rev clear", 8'(rev), 8'h00);
    wr(4'ha, 8'h7f, '{8'h44, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    rd(8'h7f, 1);
    chk("low open", got[0], 8'h44);
    $display("test rev_protect done");
    // Permanent flag survives reset and refuses the command
    wr(4'h6, 8'h00, z, 0, 1'b1);
    chk("perm set", 8'(perm), 8'h01);
    wr(4'h6, 8'h02, z, 0, 1'b0);
    wr(4'ha, 8'h7f, '{8'h55, 8'h00, 8'h00, 8'h00}, 1, 1'b1);
    rd(8'h7f, 1);
    chk("perm blocked", got[0], 8'h44);
    do_reset();
    chk("perm kept", 8'(perm), 8'h01);
    $display("test perm_protect done");
    final_report();
  end
endmodule

bind swp_eeprom_top swp_eeprom_monitor #(.PROG_CYC(PROG_CYC)) mon_u
(
  .ref_clk_in                  (ref_clk_in),
  .nrst_in                     (nrst_in),
  .scl_in                      (scl_in),
  .sda_out                     (sda_out),
  .sda_oe_out                  (sda_oe_out),
  .wp_in                       (wp_in),
  .busy_out                    (busy_out),
  .permanent_protect_flag_out  (permanent_protect_flag_out),
  .reversible_protect_flag_out (reversible_protect_flag_out)
);
